//--- rtl/node_phy_regs.sv
// Added by the designer: the APB interface to the registers.
module node_phy_regs
	import node_phy_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	input  node_phy_pkg::phy_status_t   phy_status,
	input  node_phy_pkg::phy_resp_t     phy_resp,
	input  wire logic                   phy_req_ready,
	output node_phy_pkg::phy_req_t      phy_req,
	output logic [15:0]                 node_id
);
	import node_phy_pkg::*;

	////////////////////////////////////////////////////////////////////
	// identity state
	logic       node_id_valid;
	logic       root;
	logic       cable_power_ok;
	logic [9:0] bus_segment_id;
	logic [5:0] phys_node_index;

	// phy access state
	logic       phy_read_complete;
	logic [3:0] phy_resp_reg_index;
	logic [7:0] phy_resp_value;
	logic       phy_read_request;
	logic       phy_write_request;
	logic [3:0] phy_target_index;
	logic [7:0] phy_write_value;
	logic       busy;
	logic       start;
	logic       sent;

	logic       wr_access;
	logic       rd_access;
	logic       hit_identity;
	logic       hit_access;
	logic       set_req;
	logic [31:0] next_prdata;

	assign wr_access    = psel && penable && pwrite;
	assign rd_access    = psel && !penable && !pwrite;
	assign hit_identity = paddr == node_identity_off;
	assign hit_access   = paddr == phy_register_access_off;
	assign set_req      = wr_access && hit_access
		&& (pwdata[read_request_bit] || pwdata[write_request_bit]);
	assign start        = (phy_read_request || phy_write_request) && !busy;

	////////////////////////////////////////////////////////////////////
	// apb answers in the access phase with no wait state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel && !penable;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel && !penable && !hit_identity && !hit_access;
	end

	always_comb
	begin
		next_prdata = 32'h0000_0000;
		if (hit_identity)
		begin
			// reserved bits stay zero
			next_prdata[node_id_valid_bit]  = node_id_valid;
			next_prdata[root_bit]           = root;
			next_prdata[cable_power_ok_bit] = cable_power_ok;
			next_prdata[bus_segment_lsb +: bus_segment_w] = bus_segment_id;
			next_prdata[node_index_lsb +: node_index_w]   = phys_node_index;
		end
		else if (hit_access)
		begin
			// reserved bits stay zero
			next_prdata[read_complete_bit]   = phy_read_complete;
			next_prdata[resp_index_lsb +: 4] = phy_resp_reg_index;
			next_prdata[resp_value_lsb +: 8] = phy_resp_value;
			next_prdata[read_request_bit]    = phy_read_request;
			next_prdata[write_request_bit]   = phy_write_request;
			next_prdata[target_index_lsb +: 4] = phy_target_index;
			next_prdata[write_value_lsb +: 8]  = phy_write_value;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (rd_access)
			prdata <= next_prdata;
	end

	////////////////////////////////////////////////////////////////////
	// identity register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			node_id_valid <= 1'b0;
		else if (phy_status.self_id_done)
			node_id_valid <= 1'b1;
		else if (phy_status.bus_reset)
			node_id_valid <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			root <= 1'b0;
		else if (phy_status.bus_reset)
			root <= phy_status.is_root;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cable_power_ok <= 1'b0;
		else
			cable_power_ok <= phy_status.cable_power_ok;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bus_segment_id <= bus_segment_reset;
		else if (wr_access && hit_identity)
			bus_segment_id <= pwdata[bus_segment_lsb +: bus_segment_w];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phys_node_index <= node_index_reset;
		else if (phy_status.self_id_done)
			phys_node_index <= phy_status.node_index;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			node_id <= {bus_segment_reset, node_index_reset};
		else
			node_id <= {bus_segment_id, phys_node_index};
	end

	////////////////////////////////////////////////////////////////////
	// phy access register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phy_target_index <= phy_access_reset[target_index_lsb +: 4];
			phy_write_value  <= phy_access_reset[write_value_lsb +: 8];
		end
		else if (wr_access && hit_access)
		begin
			phy_target_index <= pwdata[target_index_lsb +: 4];
			phy_write_value  <= pwdata[write_value_lsb +: 8];
		end
	end

	// software sets while not busy, hardware clears once sent; a set during busy is ignored
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phy_read_request  <= phy_access_reset[read_request_bit];
			phy_write_request <= phy_access_reset[write_request_bit];
		end
		else if (set_req && !busy)
		begin
			phy_read_request  <= pwdata[read_request_bit];
			phy_write_request <= pwdata[write_request_bit];
		end
		else if (sent)
		begin
			phy_read_request  <= 1'b0;
			phy_write_request <= 1'b0;
		end
	end

	// request in flight; ignored sets while busy
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			busy <= 1'b0;
		else if (start)
			busy <= 1'b1;
		else if (sent)
			busy <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phy_read_complete <= phy_access_reset[read_complete_bit];
		else if (phy_resp.valid)
			phy_read_complete <= 1'b1;
		else if (set_req)
			phy_read_complete <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phy_resp_reg_index <= phy_access_reset[resp_index_lsb +: 4];
			phy_resp_value     <= phy_access_reset[resp_value_lsb +: 8];
		end
		else if (phy_resp.valid)
		begin
			phy_resp_reg_index <= phy_resp.index;
			phy_resp_value     <= phy_resp.value;
		end
	end

	////////////////////////////////////////////////////////////////////
	// write wins if software broke exclusivity
	phy_req_sender u_sender (
		.pclk          (pclk),
		.presetn       (presetn),
		.start         (start),
		.start_write   (phy_write_request),
		.start_index   (phy_target_index),
		.start_value   (phy_write_value),
		.phy_req_ready (phy_req_ready),
		.phy_req       (phy_req),
		.sent          (sent)
	);

endmodule : node_phy_regs

//--- rtl/node_phy_pkg.sv
package node_phy_pkg;

	localparam logic [11:0] node_identity_off       = 12'h0e8;
	localparam logic [11:0] phy_register_access_off = 12'h0ec;

	// node identity fields
	localparam int node_id_valid_bit  = 31;
	localparam int root_bit           = 30;
	localparam int cable_power_ok_bit = 27;
	localparam int bus_segment_lsb    = 6;
	localparam int bus_segment_w      = 10;
	localparam int node_index_lsb     = 0;
	localparam int node_index_w       = 6;
	localparam logic [9:0] bus_segment_reset = 10'h3ff;
	localparam logic [5:0] node_index_reset  = 6'h3f;

	// phy access fields
	localparam int read_complete_bit = 31;
	localparam int resp_index_lsb    = 24;
	localparam int resp_value_lsb    = 16;
	localparam int read_request_bit  = 15;
	localparam int write_request_bit = 14;
	localparam int target_index_lsb  = 8;
	localparam int write_value_lsb   = 0;
	localparam logic [31:0] phy_access_reset = 32'h0000_0000;

	// request towards the phy core
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [3:0] index;
		logic [7:0] value;
	} phy_req_t;

	// register transfer coming back from the phy core
	typedef struct packed {
		logic       valid;
		logic [3:0] index;
		logic [7:0] value;
	} phy_resp_t;

	// identity events from the phy core
	typedef struct packed {
		logic       bus_reset;
		logic       self_id_done;
		logic [5:0] node_index;
		logic       is_root;
		logic       cable_power_ok;
	} phy_status_t;

	typedef enum logic [1:0] {
		req_idle = 2'b00,
		req_send = 2'b01,
		req_wait = 2'b10
	} req_state_t;

endpackage : node_phy_pkg

//--- rtl/phy_req_sender.sv
// hands one request to the phy core and waits for its acceptance
module phy_req_sender
	import node_phy_pkg::*;
(
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   start,
	input  wire logic                   start_write,
	input  wire logic [3:0]             start_index,
	input  wire logic [7:0]             start_value,
	input  wire logic                   phy_req_ready,
	output node_phy_pkg::phy_req_t      phy_req,
	output logic                        sent
);
	import node_phy_pkg::*;

	req_state_t state;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state   <= req_idle;
			phy_req <= '0;
			sent    <= 1'b0;
		end
		else
		begin
			sent <= 1'b0;
			case (state)
				req_idle:
				begin
					if (start)
					begin
						// one transaction with index and, for writes, data
						phy_req.valid <= 1'b1;
						phy_req.write <= start_write;
						phy_req.index <= start_index;
						phy_req.value <= start_write ? start_value : 8'h00;
						state         <= req_send;
					end
				end
				req_send:
				begin
					if (phy_req_ready)
					begin
						phy_req.valid <= 1'b0;
						sent          <= 1'b1;
						state         <= req_wait;
					end
				end
				req_wait:
					state <= req_idle;
				default:
					state <= req_idle;
			endcase
		end
	end

endmodule : phy_req_sender

//--- test/node_phy_props.sv
module node_phy_props
	import node_phy_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input phy_status_t      phy_status,
	input phy_resp_t        phy_resp,
	input wire logic        phy_req_ready,
	input phy_req_t         phy_req,
	input wire logic [15:0] node_id
);
	timeunit 1ns;
	timeprecision 1ps;
	import node_phy_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic        rd;
	logic        wr;
	logic        wa;
	logic [31:0] last_wd;
	assign rd = psel && penable && !pwrite;
	assign wr = psel && penable && pwrite;
	assign wa = wr && paddr == phy_register_access_off && !phy_req.valid;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			last_wd <= '0;
		else if (wa)
			last_wd <= pwdata;
	chk_id_reserved: assert property (
		rd && paddr == node_identity_off |->
		prdata[29:28] == '0 && prdata[26:16] == '0)
		else $error("identity spare bits set");
	chk_acc_reserved: assert property (
		rd && paddr == phy_register_access_off |->
		prdata[30:28] == '0 && prdata[13:12] == '0)
		else $error("access spare bits set");
	chk_segment_in_id: assert property (
		wr && paddr == node_identity_off |->
		##2 node_id[15:6] == $past(pwdata[15:6], 2))
		else $error("segment missing from node id");
	chk_index_in_id: assert property (
		phy_status.self_id_done ##1 !phy_status.self_id_done |->
		##1 node_id[5:0] == $past(phy_status.node_index, 2))
		else $error("node index not loaded");
	chk_write_sent: assert property (
		wa && pwdata[14] |-> ##[1:3] (phy_req.valid && phy_req.write
		&& phy_req.index == last_wd[11:8]
		&& phy_req.value == last_wd[7:0]))
		else $error("write request not sent");
	chk_read_sent: assert property (
		wa && pwdata[15] && !pwdata[14] |-> ##[1:3] (phy_req.valid
		&& !phy_req.write && phy_req.index == last_wd[11:8]
		&& phy_req.value == '0))
		else $error("read request not sent");
	chk_req_held: assert property (
		phy_req.valid && !phy_req_ready |=>
		phy_req.valid && $stable(phy_req))
		else $error("request dropped before acceptance");
	chk_req_once: assert property (
		phy_req.valid && phy_req_ready |=> !phy_req.valid)
		else $error("request repeated");
	cover property (wa);
	cover property (phy_resp.valid);
	cover property (phy_status.self_id_done);
endmodule : node_phy_props

bind node_phy_regs node_phy_props i_node_phy_props (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .phy_status(phy_status),
	.phy_resp(phy_resp), .phy_req_ready(phy_req_ready),
	.phy_req(phy_req), .node_id(node_id)
);

//--- test/phy_core_model.sv
module phy_core_model
	import node_phy_pkg::*;
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  phy_req_t        phy_req,
	input  wire logic [1:0] lag,
	output logic            phy_req_ready,
	output phy_resp_t       phy_resp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] regs [16];
	logic [1:0] waited;
	assign phy_req_ready = phy_req.valid && waited >= lag;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			waited <= '0;
			phy_resp <= '0;
		end
		else
		begin
			waited <= (phy_req_ready || !phy_req.valid) ? '0 : waited + 2'h1;
			if (phy_req_ready && phy_req.write)
				regs[phy_req.index] <= phy_req.value;
			if (phy_req_ready && !phy_req.write)
				phy_resp <= '{1'b1, phy_req.index, regs[phy_req.index]};
			else
				// idle lines toggle so stale data never looks like an answer
				phy_resp <= '{1'b0, ~phy_resp.index, ~phy_resp.value};
		end
	end
endmodule : phy_core_model

//--- test/test_node_phy_regs.sv
module test_node_phy_regs
	import node_phy_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [11:0] ia = node_identity_off;
	localparam logic [11:0] aa = phy_register_access_off;
	typedef struct packed {
		logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;
	} row_t;
	row_t        rows [6] = '{
		'{1'b0, ia, 32'h0, 32'h0000_ffff, 1'b0},
		'{1'b0, aa, 32'h0, 32'h0, 1'b0},
		'{1'b1, ia, 32'hffff_0000, 32'h0, 1'b0},
		'{1'b0, ia, 32'h0, 32'h0000_003f, 1'b0},
		'{1'b1, 12'h0f0, 32'hffff_ffff, 32'h0, 1'b1},
		'{1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1}};
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        er;
	logic        phy_req_ready;
	logic [1:0]  lag = '0;
	logic [7:0]  v;
	logic [15:0] node_id;
	phy_status_t phy_status = '0;
	phy_resp_t   phy_resp;
	phy_req_t    phy_req;
	int          err_total = 0;
	int          checked = 0;
	always #5 pclk = ~pclk;
	node_phy_regs i_node_phy_regs (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phy_status(phy_status), .phy_resp(phy_resp),
		.phy_req_ready(phy_req_ready), .phy_req(phy_req),
		.node_id(node_id));
	phy_core_model i_phy_core_model (.pclk(pclk), .presetn(presetn),
		.phy_req(phy_req), .lag(lag), .phy_req_ready(phy_req_ready),
		.phy_resp(phy_resp));
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish
	task automatic cmp(input string n, input logic [31:0] e, g);
		checked++;
		if (g !== e)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1)
			@(posedge pclk);
		cmp("pready", 32'h1, {31'h0, pready});
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic poll;
		for (int n = 0; n < 40; n++)
		begin
			apb(1'b0, aa, '0);
			if (rd[15:14] === 2'h0)
				break;
		end
		cmp("request bits", 32'h0, {30'h0, rd[15:14]});
	endtask : poll
	task automatic ident(input logic [5:0] ix, input logic rt, cp, sid);
		phy_status <= '{1'b1, 1'b0, 6'h0, rt, cp};
		@(posedge pclk);
		phy_status <= '{1'b0, sid, ix, rt, cp};
		@(posedge pclk);
		phy_status.self_id_done <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(1'b0, ia, '0);
	endtask : ident
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (rows[i])
		begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w)
				cmp("rdata", rows[i].e, rd);
			cmp("pslverr", {31'h0, rows[i].s}, {31'h0, er});
		end
		$display("test table done");
		ident(6'h05, 1'b1, 1'b1, 1'b1);
		cmp("identity", 32'hc800_0005, rd);
		cmp("node_id", 32'h0000_0005, {16'h0, node_id});
		ident(6'h3f, 1'b0, 1'b0, 1'b0);
		cmp("identity", 32'h0000_0005, rd);
		$display("test identity done");
		for (int k = 0; k < 2; k++)
		begin
			lag <= k ? 2'h3 : 2'h0;
			v = k ? 8'h5a : 8'ha5;
			apb(1'b1, aa, {16'h0, 8'h43, v});
			poll();
			cmp("phy write", {k ? 16'h03a5 : 16'h0000, 8'h03, v}, rd);
			apb(1'b1, aa, {16'h0, 8'h83, 8'hff});
			poll();
			cmp("phy read", {8'h83, v, 8'h03, 8'hff}, rd);
		end
		$display("test phy access done");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, ia, '0);
		cmp("reset id", 32'h0000_ffff, rd);
		apb(1'b0, aa, '0);
		cmp("reset access", 32'h0, rd);
		$display("test reset done");
		tally_and_finish();
	end
	initial
	begin
		#100000;
		err_total++;
		tally_and_finish();
	end
endmodule : test_node_phy_regs
